// [pkg/atctc_defs.vh]
// Constants of the cell block
`ifndef ATCTC_DEFS_VH
`define ATCTC_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define ATCTC_CTRL 8'h00
`define ATCTC_EVENT 8'h04
`define ATCTC_STATUS 8'h08
`define ATCTC_COUNTS 8'h0c
`define ATCTC_TX_HEAD 8'h10
`define ATCTC_TX_GO 8'h14
`define ATCTC_RX_HEAD 8'h18
`define ATCTC_RX_INFO 8'h1c
`define ATCTC_RX_RELEASE 8'h20
`define ATCTC_HEAD_MASK 8'h24
`define ATCTC_LUT_EN 8'h28
`define ATCTC_CRC_CMD 8'h2c
`define ATCTC_CRC_VAL 8'h30
`define ATCTC_TX_BUF 8'h40
`define ATCTC_RX_BUF 8'h80
`define ATCTC_LUT 8'hc0
// ****************************************
// Control bits
// ****************************************
`define ATCTC_C_TX_EN 0
`define ATCTC_C_RX_EN 1
`define ATCTC_C_SCRAM 2
`define ATCTC_C_COSET 3
`define ATCTC_C_IDLE 4
`define ATCTC_C_SRC 5
// ****************************************
// Event bits (low byte, write one to clear)
// ****************************************
`define ATCTC_E_RX 0
`define ATCTC_E_TX 1
`define ATCTC_E_NOBUF 2
`define ATCTC_E_CTRL 3
`define ATCTC_E_HEC 4
`define ATCTC_E_SYNC 6
`define ATCTC_E_MISS 7
// ****************************************
// Cell layout and fixed patterns
// ****************************************
`define ATCTC_CELL_LAST 6'd52
`define ATCTC_HEC_IDX 6'd4
`define ATCTC_PAY_IDX 6'd5
`define ATCTC_COSET 8'h55
`define ATCTC_UNASSIGNED 32'h00000000
`define ATCTC_IDLE_HEAD 32'h00000001
`define ATCTC_IDLE_FILL 8'h6a
`define ATCTC_HEC_POLY 8'h07
`define ATCTC_CRC32_POLY 32'h04c11db7
`define ATCTC_ALPHA_RST 4'h7
`define ATCTC_DELTA_RST 4'h6
`endif

// [verilog/atctc_top.v]
// Cell transmission-convergence layer
// Summary of operation
// - Cells are exactly 53 bytes; UNI and NNI headers both pass unchanged.
// - Transmit inserts computed header check octet; receive checks it and strips it.
// - Coset option XORs 01010101 into header check octet on both directions.
// - With no queued host cell, an empty cell is sent to fill the link.
// - Received empty cells are dropped and never delivered.
// - Host selects unassigned or idle format for transmitted empty cells.
// - Errored-header cells are delivered, flagged, with received check octet, uncorrected.
// - Optional x^43+1 payload scrambling both ways, 43-bit delay line.
// - First cell after reset is always empty, covering delay line fill.
// - Descrambler runs always, synchronised before lock.
// - Headers compared against 16-entry table; masked bits excluded.
// - Cells matching neither table nor external match are discarded.
// - One control bit selects internal table (0) or external match (1).
// - Transmit header fields and payload are taken exactly as the host gives.
// - Host cells go out one at a time in presented order.
// - Delineation hunts on octet boundaries using header check.
// - Once locked, lock is kept until too many header check errors.
// - Lock changes raise an event; a status bit shows present lock.
// - CRC-32 is a separate host command over a data buffer.
// - Fixed-length buffers, separate transmit and receive regions.
// - Low-byte event flags are sticky and cleared by writing one.
// - Header error event is set at check time, before cell end.
`include "atctc_defs.vh"
module atctc_top (
    input wire i_clk,
    input wire i_resetn,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire i_link_clk,
    input wire i_rx_data,
    input wire i_rx_sync,
    input wire i_ext_hit,
    output reg o_tx_data,
    output reg [31:0] o_ext_key,
    output reg o_sync_state
);
    localparam ST_HUNT = 3'b001;
    localparam ST_PRE = 3'b010;
    localparam ST_SYNC = 3'b100;

    // ****************************************
    // Functions
    // ****************************************
    // Header check remainder over four octets
    function [7:0] atctc_hec;
        input [31:0] h;
        integer k;
        reg [7:0] c;
        begin
            c = 8'h00;
            for (k = 31; k >= 0; k = k - 1) begin
                c = {c[6:0], 1'b0} ^ ((c[7] ^ h[k]) ? `ATCTC_HEC_POLY : 8'h00);
            end
            atctc_hec = c;
        end
    endfunction

    // CRC-32 step over one byte, most significant bit first
    function [31:0] atctc_crc32;
        input [31:0] c_in;
        input [7:0] d;
        integer k;
        reg [31:0] c;
        begin
            c = c_in;
            for (k = 7; k >= 0; k = k - 1) begin
                c = {c[30:0], 1'b0} ^ ((c[31] ^ d[k]) ? `ATCTC_CRC32_POLY : 32'h00000000);
            end
            atctc_crc32 = c;
        end
    endfunction

    // ****************************************
    // Registers and memories
    // ****************************************
    reg [5:0] ctrl;
    reg [7:0] events;
    reg [3:0] alpha;
    reg [3:0] delta;
    reg [31:0] tx_head;
    reg tx_queued;
    reg [31:0] rx_head;
    reg [7:0] rx_hec;
    reg rx_err;
    reg rx_full;
    reg [31:0] head_mask;
    reg [15:0] lut_en;
    reg [31:0] crc_val;
    reg crc_busy;
    reg [5:0] crc_idx;
    reg [7:0] tx_mem [0:47];
    reg [7:0] rx_mem [0:47];
    reg [31:0] lut [0:15];
    reg [7:0] ev_set;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    reg dp_wr;
    reg rd_pend;
    reg [7:0] dp_addr;
    wire ap_take = i_hsel & i_htrans[1] & i_hready;
    wire [5:0] wbase = {dp_addr[5:2], 2'b00};

    // Read mux; unmapped reads zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        if (dp_addr >= `ATCTC_LUT)
            rd_mux = lut[dp_addr[5:2]];
        else if (dp_addr >= `ATCTC_RX_BUF && dp_addr < `ATCTC_RX_BUF + 8'h30)
            rd_mux = {rx_mem[wbase], rx_mem[wbase + 6'd1], rx_mem[wbase + 6'd2], rx_mem[wbase + 6'd3]};
        else if (dp_addr >= `ATCTC_TX_BUF && dp_addr < `ATCTC_TX_BUF + 8'h30)
            rd_mux = {tx_mem[wbase], tx_mem[wbase + 6'd1], tx_mem[wbase + 6'd2], tx_mem[wbase + 6'd3]};
        else begin
            case (dp_addr)
                `ATCTC_CTRL: rd_mux = {26'h0, ctrl};
                `ATCTC_EVENT: rd_mux = {24'h0, events};
                `ATCTC_STATUS: rd_mux = {28'h0, crc_busy, rx_full, tx_queued, o_sync_state};
                `ATCTC_COUNTS: rd_mux = {20'h0, delta, 4'h0, alpha};
                `ATCTC_TX_HEAD: rd_mux = tx_head;
                `ATCTC_RX_HEAD: rd_mux = rx_head;
                `ATCTC_RX_INFO: rd_mux = {23'h0, rx_err, rx_hec};
                `ATCTC_HEAD_MASK: rd_mux = head_mask;
                `ATCTC_LUT_EN: rd_mux = {16'h0, lut_en};
                `ATCTC_CRC_VAL: rd_mux = crc_val;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // Reads take one wait state so a write just before is always seen
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            dp_wr <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            dp_wr <= ap_take & i_hwrite;
            rd_pend <= ap_take & ~i_hwrite;
            if (ap_take)
                dp_addr <= {i_haddr[7:2], 2'b00};
            o_hreadyout <= ~(ap_take & ~i_hwrite);
            if (rd_pend)
                o_hrdata <= rd_mux;
        end
    end
    wire wr_go = dp_wr;

    // ****************************************
    // Link sampling
    // ****************************************
    // Two-flop synchronisers
    reg [1:0] lclk_s;
    reg [1:0] rxd_s;
    reg [1:0] rxs_s;
    reg [1:0] hit_s;
    reg lclk_q;
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            lclk_s <= 2'b00;
            rxd_s <= 2'b00;
            rxs_s <= 2'b00;
            hit_s <= 2'b00;
            lclk_q <= 1'b0;
        end else begin
            lclk_s <= {lclk_s[0], i_link_clk};
            rxd_s <= {rxd_s[0], i_rx_data};
            rxs_s <= {rxs_s[0], i_rx_sync};
            hit_s <= {hit_s[0], i_ext_hit};
            lclk_q <= lclk_s[1];
        end
    end
    wire bit_en = lclk_s[1] & ~lclk_q;

    // ****************************************
    // Transmit path
    // ****************************************
    reg [5:0] tx_idx;
    reg [2:0] tx_bit;
    reg [7:0] tx_sh;
    reg [42:0] scr;
    reg cur_data;
    reg first_sent;
    wire next_data = tx_queued & first_sent;
    wire use_data = (tx_idx == 6'd0) ? next_data : cur_data;
    wire [31:0] empty_head = ctrl[`ATCTC_C_IDLE] ? `ATCTC_IDLE_HEAD : `ATCTC_UNASSIGNED;
    wire [31:0] tx_word = use_data ? tx_head : empty_head;
    wire [7:0] coset = ctrl[`ATCTC_C_COSET] ? `ATCTC_COSET : 8'h00;
    reg [7:0] tx_byte;
    always @* begin
        case (tx_idx)
            6'd0: tx_byte = tx_word[31:24];
            6'd1: tx_byte = tx_word[23:16];
            6'd2: tx_byte = tx_word[15:8];
            6'd3: tx_byte = tx_word[7:0];
            6'd4: tx_byte = atctc_hec(tx_word) ^ coset;
            default: tx_byte = use_data ? tx_mem[tx_idx - `ATCTC_PAY_IDX] : `ATCTC_IDLE_FILL;
        endcase
    end
    wire tx_raw = (tx_bit == 3'd0) ? tx_byte[7] : tx_sh[7];
    wire tx_pay = tx_idx >= `ATCTC_PAY_IDX;
    wire tx_out = tx_raw ^ (ctrl[`ATCTC_C_SCRAM] & tx_pay & scr[42]);
    wire tx_cell_end = bit_en & ctrl[`ATCTC_C_TX_EN] & (tx_bit == 3'd7) & (tx_idx == `ATCTC_CELL_LAST);

    // Bit and byte sequencing
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_idx <= 6'd0;
            tx_bit <= 3'd0;
            tx_sh <= 8'h00;
            scr <= 43'h0;
            cur_data <= 1'b0;
            first_sent <= 1'b0;
            o_tx_data <= 1'b1;
        end else if (bit_en && ctrl[`ATCTC_C_TX_EN]) begin
            o_tx_data <= tx_out;
            tx_sh <= (tx_bit == 3'd0) ? {tx_byte[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
            if (tx_pay)
                scr <= {scr[41:0], tx_out};
            tx_bit <= tx_bit + 3'd1;
            if (tx_bit == 3'd0 && tx_idx == 6'd0) begin
                cur_data <= next_data;
                first_sent <= 1'b1;
            end
            if (tx_bit == 3'd7)
                tx_idx <= (tx_idx == `ATCTC_CELL_LAST) ? 6'd0 : tx_idx + 6'd1;
        end
    end

    // ****************************************
    // Receive path
    // ****************************************
    reg [2:0] rx_bit;
    reg [7:0] rx_sh;
    reg [7:0] rx_dsh;
    reg [42:0] dsc;
    reg [31:0] win;
    reg [2:0] dstate;
    reg [3:0] pcnt;
    reg [3:0] ecnt;
    reg [5:0] rx_idx;
    reg rx_take;
    reg cell_err;
    reg [7:0] cell_hec;
    wire rbit = rxd_s[1];
    wire dbit = rbit ^ dsc[42];
    wire [2:0] bcnt = rxs_s[1] ? 3'd0 : rx_bit;
    wire byte_done = bit_en & ctrl[`ATCTC_C_RX_EN] & (bcnt == 3'd7);
    wire [7:0] rbyte = {rx_sh[6:0], rbit};
    wire [7:0] dbyte = {rx_dsh[6:0], dbit};
    wire [7:0] pbyte = ctrl[`ATCTC_C_SCRAM] ? dbyte : rbyte;
    wire [39:0] nwin = {win, rbyte};
    wire hec_ok = (atctc_hec(nwin[39:8]) ^ coset) == nwin[7:0];
    wire is_empty = (nwin[39:8] == `ATCTC_UNASSIGNED) || (nwin[39:8] == `ATCTC_IDLE_HEAD);

    // Table compare with masked bits excluded
    reg int_hit;
    integer m;
    always @* begin
        int_hit = 1'b0;
        for (m = 0; m < 16; m = m + 1) begin
            if (lut_en[m] && (((lut[m] ^ o_ext_key) & ~head_mask) == 32'h00000000))
                int_hit = 1'b1;
        end
    end
    wire addr_hit = ctrl[`ATCTC_C_SRC] ? hit_s[1] : int_hit;

    // Delineation, descrambling and cell capture
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rx_bit <= 3'd0;
            rx_sh <= 8'h00;
            rx_dsh <= 8'h00;
            dsc <= 43'h0;
            win <= 32'h00000000;
            dstate <= ST_HUNT;
            pcnt <= 4'h0;
            ecnt <= 4'h0;
            rx_idx <= 6'd0;
            rx_take <= 1'b0;
            cell_err <= 1'b0;
            cell_hec <= 8'h00;
            o_ext_key <= 32'h00000000;
            o_sync_state <= 1'b0;
            ev_set <= 8'h00;
        end else begin
            ev_set <= 8'h00;
            if (bit_en && ctrl[`ATCTC_C_RX_EN]) begin
                rx_bit <= bcnt + 3'd1;
                rx_sh <= rbyte;
                rx_dsh <= dbyte;
                dsc <= {dsc[41:0], rbit};
            end
            if (byte_done) begin
                win <= nwin[31:0];
                rx_idx <= (rx_idx == `ATCTC_CELL_LAST) ? 6'd0 : rx_idx + 6'd1;
                case (dstate)
                    ST_HUNT: begin
                        if (hec_ok) begin
                            dstate <= ST_PRE;
                            pcnt <= 4'h0;
                            rx_idx <= `ATCTC_PAY_IDX;
                        end
                    end
                    ST_PRE: begin
                        if (rx_idx == `ATCTC_HEC_IDX) begin
                            if (!hec_ok)
                                dstate <= ST_HUNT;
                            else if (pcnt + 4'h1 >= delta) begin
                                dstate <= ST_SYNC;
                                ecnt <= 4'h0;
                                o_sync_state <= 1'b1;
                                ev_set[`ATCTC_E_SYNC] <= 1'b1;
                            end else
                                pcnt <= pcnt + 4'h1;
                        end
                    end
                    ST_SYNC: begin
                        if (rx_idx == `ATCTC_HEC_IDX) begin
                            o_ext_key <= nwin[39:8];
                            cell_hec <= nwin[7:0];
                            cell_err <= ~hec_ok;
                            rx_take <= ~is_empty;
                            if (hec_ok)
                                ecnt <= 4'h0;
                            else begin
                                ev_set[`ATCTC_E_HEC] <= 1'b1;
                                ecnt <= ecnt + 4'h1;
                                if (ecnt + 4'h1 >= alpha) begin
                                    dstate <= ST_HUNT;
                                    o_sync_state <= 1'b0;
                                    rx_take <= 1'b0;
                                    ev_set[`ATCTC_E_SYNC] <= 1'b1;
                                end
                            end
                        end
                        if (rx_idx >= `ATCTC_PAY_IDX && rx_take && !rx_full)
                            rx_mem[rx_idx - `ATCTC_PAY_IDX] <= pbyte;
                        if (rx_idx == `ATCTC_CELL_LAST && rx_take) begin
                            rx_take <= 1'b0;
                            if (!addr_hit)
                                ev_set[`ATCTC_E_MISS] <= 1'b1;
                            else if (rx_full)
                                ev_set[`ATCTC_E_NOBUF] <= 1'b1;
                            else begin
                                ev_set[`ATCTC_E_RX] <= 1'b1;
                                ev_set[`ATCTC_E_CTRL] <= o_ext_key[3];
                            end
                        end
                    end
                    default: dstate <= ST_HUNT;
                endcase
            end
        end
    end
    wire deliver = ev_set[`ATCTC_E_RX];

    // ****************************************
    // Register writes, events, queue and CRC-32 command
    // ****************************************
    wire [7:0] wr_clr = (wr_go && dp_addr == `ATCTC_EVENT) ? i_hwdata[7:0] : 8'h00;
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            ctrl <= 6'h00;
            events <= 8'h00;
            alpha <= `ATCTC_ALPHA_RST;
            delta <= `ATCTC_DELTA_RST;
            tx_head <= 32'h00000000;
            tx_queued <= 1'b0;
            rx_head <= 32'h00000000;
            rx_hec <= 8'h00;
            rx_err <= 1'b0;
            rx_full <= 1'b0;
            head_mask <= 32'h00000000;
            lut_en <= 16'h0000;
            crc_val <= 32'h00000000;
            crc_busy <= 1'b0;
            crc_idx <= 6'd0;
        end else begin
            // Set wins over a clear landing in the same cycle
            events <= (events & ~wr_clr) | ev_set | {6'h00, tx_cell_end & cur_data, 1'b0};
            if (tx_cell_end && cur_data)
                tx_queued <= 1'b0;
            if (deliver) begin
                rx_full <= 1'b1;
                rx_head <= o_ext_key;
                rx_hec <= cell_hec;
                rx_err <= cell_err;
            end
            if (crc_busy) begin
                crc_val <= atctc_crc32(crc_val, tx_mem[crc_idx]);
                crc_idx <= crc_idx + 6'd1;
                if (crc_idx == 6'd47)
                    crc_busy <= 1'b0;
            end
            if (wr_go) begin
                if (dp_addr >= `ATCTC_LUT)
                    lut[dp_addr[5:2]] <= i_hwdata;
                else if (dp_addr >= `ATCTC_TX_BUF && dp_addr < `ATCTC_TX_BUF + 8'h30) begin
                    tx_mem[wbase] <= i_hwdata[31:24];
                    tx_mem[wbase + 6'd1] <= i_hwdata[23:16];
                    tx_mem[wbase + 6'd2] <= i_hwdata[15:8];
                    tx_mem[wbase + 6'd3] <= i_hwdata[7:0];
                end
                case (dp_addr)
                    `ATCTC_CTRL: ctrl <= i_hwdata[5:0];
                    `ATCTC_COUNTS: begin
                        alpha <= i_hwdata[3:0];
                        delta <= i_hwdata[11:8];
                    end
                    `ATCTC_TX_HEAD: tx_head <= i_hwdata;
                    `ATCTC_TX_GO: tx_queued <= 1'b1;
                    `ATCTC_RX_RELEASE: rx_full <= deliver;
                    `ATCTC_HEAD_MASK: head_mask <= i_hwdata;
                    `ATCTC_LUT_EN: lut_en <= i_hwdata[15:0];
                    `ATCTC_CRC_CMD: begin
                        // b0 walks the tx buffer, b1 seeds ones
                        if (i_hwdata[1])
                            crc_val <= 32'hffffffff;
                        if (i_hwdata[0] && !crc_busy) begin
                            crc_busy <= 1'b1;
                            crc_idx <= 6'd0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// [tb/atctc_line_model.sv]
// Line side model: cell source and transmit spotter
module atctc_line_model (
    output logic o_link_clk,
    output logic o_rx_data,
    output logic o_rx_sync,
    input wire logic i_tx_data,
    input wire logic [31:0] i_head,
    input wire logic i_bad,
    input wire logic [39:0] i_want,
    output logic o_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] sr = '1;
    // Header check octet, MSB first
    function automatic logic [7:0] crc8(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // Trunk clock runs free, as a TDM line does
    initial begin
        o_link_clk = 1'b0;
        forever #40 o_link_clk = ~o_link_clk;
    end
    // Cells back to back; bits change on the falling edge
    initial begin
        logic [7:0] b;
        logic [31:0] h;
        o_rx_data = 1'b1;
        o_rx_sync = 1'b0;
        forever begin
            h = i_head;
            for (int k = 0; k < 53; k++) begin
                b = k < 4 ? h[31 - 8 * k -: 8] : k == 4 ? crc8(h) ^ {7'h00, i_bad} : 8'(k - 5);
                for (int n = 7; n >= 0; n--) begin
                    @(negedge o_link_clk);
                    o_rx_data <= b[n];
                    o_rx_sync <= (n == 7);
                end
            end
        end
    end
    // Spot the wanted header and check octet
    always @(posedge o_link_clk) begin
        sr = {sr[38:0], i_tx_data};
        o_seen <= (sr == i_want);
    end
endmodule

// [tb/atctc_checker.sv]
// Port assertions for the cell block
module atctc_checker (
    input wire i_clk,
    input wire i_resetn,
    input wire i_hsel,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] o_hrdata,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire o_tx_data,
    input wire [31:0] o_ext_key,
    input wire o_sync_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire taken = i_hsel & i_htrans[1] & i_hready;
    // A read costs exactly one wait state
    sequence s_wait_one; !o_hreadyout ##1 o_hreadyout; endsequence
    property p_rd_wait; taken && !i_hwrite |=> s_wait_one; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state count wrong");
    property p_wr_nowait; taken && i_hwrite |=> o_hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled the bus");
    property p_stall_cause; $fell(o_hreadyout) |-> $past(taken && !i_hwrite); endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("stall without a read");
    property p_okay; o_hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_data_moment; $changed(o_hrdata) |-> $rose(o_hreadyout); endproperty
    a_data_moment: assert property (p_data_moment) else $error("read data moved outside a read end");
    // Not masked by the default disable
    property p_reset_out;
        disable iff (1'b0) !i_resetn |=> o_hreadyout && !o_hresp && o_hrdata == 32'h0 && o_tx_data
            && o_ext_key == 32'h0 && !o_sync_state;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs wrong in reset");
    property p_lock_holds; $rose(o_sync_state) |=> o_sync_state [*8]; endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("lock dropped at once");
    property p_bit_period; $changed(o_tx_data) |=> $stable(o_tx_data) [*6]; endproperty
    a_bit_period: assert property (p_bit_period) else $error("line bit shorter than a link period");
endmodule
bind atctc_top atctc_checker chk_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_tx_data(o_tx_data), .o_ext_key(o_ext_key), .o_sync_state(o_sync_state));

// [tb/atm_cell_tc_layer_tb_top.sv]
// Cell block bench over AHB-Lite
`include "atctc_defs.vh"
module atm_cell_tc_layer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] H1 = 32'h0a5c3e20;
    localparam logic [31:0] H2 = 32'h0a5c3f20;
    localparam logic [31:0] H3 = 32'h7f00ffe2;
    logic i_clk, i_resetn, hsel, hwrite, ext_hit, bad;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rdata, head;
    logic [39:0] want;
    wire [31:0] hrdata, ext_key;
    wire hready, hresp, link_clk, rx_data, rx_sync, tx_data, sync_state, seen;
    int mismatches, checks_done;
    atctc_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_link_clk(link_clk), .i_rx_data(rx_data), .i_rx_sync(rx_sync),
        .i_ext_hit(ext_hit), .o_tx_data(tx_data), .o_ext_key(ext_key), .o_sync_state(sync_state));
    atctc_line_model line_u (.o_link_clk(link_clk), .o_rx_data(rx_data), .o_rx_sync(rx_sync),
        .i_tx_data(tx_data), .i_head(head), .i_bad(bad), .i_want(want), .o_seen(seen));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Single transfer; waits on hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge i_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'b1);
        rdata = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata & m, exp);
    endtask
    // Poll an event flag
    task automatic wait_ev(input int b);
        rdata = 32'h0;
        for (int i = 0; i < 3000 && rdata[b] !== 1'b1; i++) bus(1'b0, `ATCTC_EVENT, 32'h0);
    endtask
    // Let the spotter take the new pattern before looking
    task automatic wait_tx(input logic [39:0] w);
        want <= w;
        repeat (10) @(posedge i_clk);
        for (int i = 0; i < 12000 && seen !== 1'b1; i++) @(posedge i_clk);
        chk({31'h0, seen}, 32'h1);
    endtask
    task automatic stop_test;
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #990000;
        mismatches++;
        stop_test;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {i_resetn, hsel, hwrite, ext_hit, bad, htrans, haddr, hwdata} = '0;
        head = H1;
        want = '1;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd_chk(`ATCTC_COUNTS, 32'hffffffff, 32'h00000607);
        rd_chk(`ATCTC_STATUS, 32'h0000000f, 32'h0);
        bus(1'b1, 8'h38, 32'hffffffff);
        rd_chk(8'h38, 32'hffffffff, 32'h0);
        // Lock, deliver one matching cell, stripped of its check octet
        bus(1'b1, `ATCTC_LUT, H1);
        bus(1'b1, `ATCTC_LUT_EN, 32'h1);
        bus(1'b1, `ATCTC_CTRL, 32'h2);
        for (int i = 0; i < 40000 && sync_state !== 1'b1; i++) @(posedge i_clk);
        rd_chk(`ATCTC_STATUS, 32'h1, 32'h1);
        rd_chk(`ATCTC_EVENT, 32'h40, 32'h40);
        bus(1'b1, `ATCTC_EVENT, 32'h40);
        rd_chk(`ATCTC_EVENT, 32'h40, 32'h0);
        wait_ev(0);
        rd_chk(`ATCTC_RX_HEAD, 32'hffffffff, H1);
        rd_chk(`ATCTC_RX_INFO, 32'h1ff, {24'h0, line_u.crc8(H1)});
        rd_chk(`ATCTC_RX_BUF + 8'h2c, 32'hffffffff, 32'h2c2d2e2f);
        // Errored headers: flagged early, delivered as received
        bus(1'b1, `ATCTC_EVENT, 32'hff);
        bad <= 1'b1;
        wait_ev(4);
        rd_chk(`ATCTC_EVENT, 32'h10, 32'h10);
        bus(1'b1, `ATCTC_RX_RELEASE, 32'h0);
        wait_ev(0);
        bad <= 1'b0;
        rd_chk(`ATCTC_RX_INFO, 32'h1ff, {23'h0, 1'b1, line_u.crc8(H1) ^ 8'h01});
        chk({31'h0, sync_state}, 32'h1);
        // Address filter: miss, masked match, external source; one cell time flushes the old header
        head <= H2;
        repeat (3500) @(posedge i_clk);
        bus(1'b1, `ATCTC_EVENT, 32'hff);
        bus(1'b1, `ATCTC_RX_RELEASE, 32'h0);
        wait_ev(7);
        rd_chk(`ATCTC_EVENT, 32'h1, 32'h0);
        bus(1'b1, `ATCTC_HEAD_MASK, H1 ^ H2);
        wait_ev(0);
        rd_chk(`ATCTC_RX_HEAD, 32'hffffffff, H2);
        bus(1'b1, `ATCTC_HEAD_MASK, 32'h0);
        bus(1'b1, `ATCTC_CTRL, 32'h22);
        ext_hit <= 1'b1;
        bus(1'b1, `ATCTC_EVENT, 32'hff);
        bus(1'b1, `ATCTC_RX_RELEASE, 32'h0);
        wait_ev(0);
        chk(ext_key, H2);
        // Empty cells never reach the host, even with a forced external hit
        head <= 32'h0;
        repeat (3500) @(posedge i_clk);
        bus(1'b1, `ATCTC_RX_RELEASE, 32'h0);
        bus(1'b1, `ATCTC_EVENT, 32'hff);
        repeat (7000) @(posedge i_clk);
        rd_chk(`ATCTC_EVENT, 32'h85, 32'h0);
        // Transmit: queued host cell waits behind the first empty cell
        for (int i = 0; i < 12; i++) bus(1'b1, `ATCTC_TX_BUF + 8'(4 * i), {4{8'(i)}});
        bus(1'b1, `ATCTC_TX_HEAD, H3);
        bus(1'b1, `ATCTC_TX_GO, 32'h0);
        bus(1'b1, `ATCTC_CTRL, 32'h23);
        wait_tx(40'h0);
        rd_chk(`ATCTC_STATUS, 32'h2, 32'h2);
        wait_tx({H3, line_u.crc8(H3)});
        wait_ev(1);
        rd_chk(`ATCTC_STATUS, 32'h2, 32'h0);
        bus(1'b1, `ATCTC_CTRL, 32'h33);
        wait_tx({32'h1, line_u.crc8(32'h1)});
        bus(1'b1, `ATCTC_CTRL, 32'h2b);
        wait_tx({32'h0, 8'h55});
        stop_test;
    end
endmodule
